//--- src/swm_defines.svh
// Constants for the standby wake manager
`ifndef SWM_DEFINES_SVH
`define SWM_DEFINES_SVH
`define SWM_CLK_HZ          40000000
`define SWM_SEC_CYCLES      (`SWM_CLK_HZ)
`define SWM_GUARD_DEF_SEC   4'ha
`define SWM_GUARD_MIN_SEC   4'h1
`define SWM_GUARD_MAX_SEC   4'hf
`define SWM_PRESC_W         26
`define SWM_WAKE_W          8
`define SWM_WK_PANEL        0
`define SWM_WK_REMOTE       1
`define SWM_WK_ALARM        2
`define SWM_WK_WDOG         3
`define SWM_WK_OSCF         4
`define SWM_WK_PIN          5
`define SWM_WK_GPIO         6
`define SWM_WK_READY        7
`endif

//--- src/swm_device.sv
// Standby wake manager, device end
//
// Overview of operation
// - Standby on ready fall, command, or timeout
// - In run, only timeout raises standby unprompted
// - After reset, power the board
// - No ready within guard period cuts power
// - Host raises ready before configuring
// - Ready assertion switches guard timer off
// - Host programs guard to keep it running
// - Power-on reset starts guard at 10s
// - Power cut low during normal operation
// - Host clears enabled guard before expiry
// - Host best leaves guard disabled
// - Eight wake sources recognised
// - Hot-key or wake pin rise ends standby
// - Standby release restarts guard timer
// - Wake period is programmed value, default 10s
// - Guard stopped throughout standby
// - Alarm wakes from standby only, ignored in run
// - Clear bit, 1-15s period, disable option
// - Guard starts on edges, not levels
// - Resume in run, reload on boot
`timescale 1ns/1ps
`include "swm_defines.svh"
module swm_device (
  input  wire logic                   sys_clk,    // 40 MHz clock
  input  wire logic                   resetn,     // Async reset, active low
  swm_link_if.dev                     link,       // Host link
  input  wire logic                   key_panel,  // Front-panel hot-key pulse
  input  wire logic                   key_remote, // Remote hot-key pulse
  input  wire logic                   rtc_alarm,  // Clock alarm pulse
  input  wire logic                   rtc_wdog,   // Clock watchdog pulse
  input  wire logic                   rtc_oscf,   // Oscillator fail pulse
  input  wire logic                   wake_pin,   // Wake pin level
  input  wire logic                   gpio_chg,   // GPIO change pulse
  output logic [`SWM_WAKE_W-1:0]      wake_cause, // Last wake source
  output logic                        guard_on    // Guard timer counting
);
  swm_pkg::swm_state_e  state_q;
  swm_pkg::swm_state_e  state_d;
  swm_pkg::swm_period_t period_q;
  logic                 guard_en_q;
  logic                 ready_q;
  logic                 wake_q;
  logic                 cut_q;
  logic [`SWM_WAKE_W-1:0] cause_q;
  wire  [`SWM_WAKE_W-1:0] wake_vec;
  wire                  ready_rise;
  wire                  ready_fall;
  wire                  pin_rise;
  wire                  any_wake;
  wire                  expire;
  wire                  tmr_load;
  wire                  tmr_run;
  wire                  in_run;
  wire                  in_boot;
  wire                  in_board_power_cut;
  wire                  cfg_ok;

  ////////////////////////////////////////////////////////////////////////
  // Edge detection, wake vector and state decode
  assign ready_rise = link.host_ready & ~ready_q;
  assign ready_fall = ~link.host_ready & ready_q;
  assign pin_rise   = wake_pin & ~wake_q;
  assign wake_vec[`SWM_WK_PANEL]  = key_panel;
  assign wake_vec[`SWM_WK_REMOTE] = key_remote;
  assign wake_vec[`SWM_WK_ALARM]  = rtc_alarm;
  assign wake_vec[`SWM_WK_WDOG]   = rtc_wdog;
  assign wake_vec[`SWM_WK_OSCF]   = rtc_oscf;
  assign wake_vec[`SWM_WK_PIN]    = pin_rise;
  assign wake_vec[`SWM_WK_GPIO]   = gpio_chg;
  assign wake_vec[`SWM_WK_READY]  = ready_rise;
  assign any_wake = |wake_vec;
  assign in_run   = (state_q == swm_pkg::SWM_ST_RUN);
  assign in_boot  = (state_q == swm_pkg::SWM_ST_BOOT);
  assign in_board_power_cut  = (state_q == swm_pkg::SWM_ST_STANDBY);
  assign cfg_ok   = link.guard_cfg_wr && (link.guard_cfg_sec >= `SWM_GUARD_MIN_SEC);

  ////////////////////////////////////////////////////////////////////////
  // Guard timer control
  // Reload on wake; reload on clear
  assign tmr_load = (in_board_power_cut && any_wake) || (in_run && link.guard_clear);
  // Stopped in standby; off while ready unless enabled; resume
  assign tmr_run  = in_boot || (in_run && guard_en_q);
  assign guard_on = tmr_run;

  swm_guard_timer u_guard (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .load    (tmr_load),
    .run     (tmr_run),
    .period  (period_q),
    .expire  (expire)
  );

  ////////////////////////////////////////////////////////////////////////
  // State transitions
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      swm_pkg::SWM_ST_BOOT: begin
        if (expire || link.cmd_standby) state_d = swm_pkg::SWM_ST_STANDBY;
        else if (ready_rise)            state_d = swm_pkg::SWM_ST_RUN;
      end
      swm_pkg::SWM_ST_RUN: begin
        if (ready_fall || link.cmd_standby || expire) state_d = swm_pkg::SWM_ST_STANDBY;
      end
      swm_pkg::SWM_ST_STANDBY: begin
        if (any_wake) state_d = swm_pkg::SWM_ST_BOOT;
      end
      default: state_d = swm_pkg::SWM_ST_STANDBY;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Registers
  // Boot with power on and 10s period
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= swm_pkg::SWM_ST_BOOT;
      ready_q <= 1'b0;
      wake_q  <= 1'b0;
      cut_q   <= 1'b0;
      cause_q <= '0;
    end else begin
      state_q <= state_d;
      ready_q <= link.host_ready;
      wake_q  <= wake_pin;
      cut_q   <= (state_d == swm_pkg::SWM_ST_STANDBY);
      if (in_board_power_cut && any_wake) cause_q <= wake_vec;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      period_q   <= `SWM_GUARD_DEF_SEC;
      guard_en_q <= 1'b0;
    end else if (cfg_ok) begin
      period_q   <= link.guard_cfg_sec;
      guard_en_q <= link.guard_cfg_en;
    end
  end

  assign link.board_power_cut = cut_q;
  assign wake_cause           = cause_q;
endmodule : swm_device

//--- src/swm_guard_timer.sv
// Guard timer: seconds countdown with load and hold
`timescale 1ns/1ps
`include "swm_defines.svh"
module swm_guard_timer (
  input  wire logic                 sys_clk,  // Clock
  input  wire logic                 resetn,   // Async reset, active low
  input  wire logic                 load,     // Restart from period
  input  wire logic                 run,      // Count when high
  input  wire swm_pkg::swm_period_t period,   // Period in seconds
  output logic                      expire    // One-cycle pulse at zero
);
  logic [`SWM_PRESC_W-1:0] presc_q;
  logic [3:0]              secs_q;
  wire                     tick;
  wire                     at_zero;
  assign tick    = (presc_q == `SWM_PRESC_W'(`SWM_SEC_CYCLES - 1));
  assign at_zero = (secs_q == 4'h1) && tick;
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      presc_q <= '0;
      secs_q  <= `SWM_GUARD_DEF_SEC;
      expire  <= 1'b0;
    end else begin
      expire <= 1'b0;
      if (load) begin
        presc_q <= '0;
        secs_q  <= period;
      end else if (run) begin
        presc_q <= tick ? '0 : presc_q + 1'b1;
        if (at_zero) begin
          secs_q <= period;
          expire <= 1'b1;
        end else if (tick) begin
          secs_q <= secs_q - 4'h1;
        end
      end
    end
  end
endmodule : swm_guard_timer

//--- src/swm_host.sv
// Standby wake manager, host end
`timescale 1ns/1ps
module swm_host (
  input  wire logic                 sys_clk,     // 40 MHz clock
  input  wire logic                 resetn,      // Async reset, active low
  swm_link_if.host                  link,        // Device link
  input  wire logic                 booted,      // Host boot complete level
  input  wire logic                 req_standby, // Standby command pulse
  input  wire logic                 req_clear,   // Guard clear pulse
  input  wire logic                 req_cfg,     // Guard config pulse
  input  wire logic                 cfg_en,      // Keep guard on while ready
  input  wire swm_pkg::swm_period_t cfg_sec,     // Guard period seconds
  output logic                      powered      // Board has power
);
  logic                 ready_q;
  logic                 board_power_cut_q;
  logic                 clr_q;
  logic                 wr_q;
  logic                 en_q;
  swm_pkg::swm_period_t sec_q;
  wire                  up;
  assign up = ~link.board_power_cut;
  // Commands only once ready; gated by ready_q here
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ready_q <= 1'b0;
      board_power_cut_q  <= 1'b0;
      clr_q   <= 1'b0;
      wr_q    <= 1'b0;
      en_q    <= 1'b0;
      sec_q   <= '0;
    end else begin
      ready_q <= up && booted;
      board_power_cut_q  <= ready_q && req_standby;
      clr_q   <= ready_q && req_clear;
      wr_q    <= ready_q && req_cfg;
      if (ready_q && req_cfg) begin
        en_q  <= cfg_en;
        sec_q <= cfg_sec;
      end
    end
  end
  assign link.host_ready    = ready_q;
  assign link.cmd_standby   = board_power_cut_q;
  assign link.guard_clear   = clr_q;
  assign link.guard_cfg_wr  = wr_q;
  assign link.guard_cfg_en  = en_q;
  assign link.guard_cfg_sec = sec_q;
  assign powered            = up;
endmodule : swm_host

//--- src/swm_link_if.sv
// Link between the standby manager and the host
`timescale 1ns/1ps
interface swm_link_if;
  logic                 board_power_cut;
  logic                 host_ready;
  logic                 cmd_standby;
  logic                 guard_clear;
  logic                 guard_cfg_wr;
  logic                 guard_cfg_en;
  swm_pkg::swm_period_t guard_cfg_sec;
  modport dev  (output board_power_cut, input host_ready, cmd_standby, guard_clear,
                input guard_cfg_wr, guard_cfg_en, guard_cfg_sec);
  modport host (input board_power_cut, output host_ready, cmd_standby, guard_clear,
                output guard_cfg_wr, guard_cfg_en, guard_cfg_sec);
endinterface : swm_link_if

//--- src/swm_pkg.sv
// Types shared by the standby wake manager ends
package swm_pkg;
  typedef enum logic [2:0] {
    SWM_ST_BOOT    = 3'b001,
    SWM_ST_RUN     = 3'b010,
    SWM_ST_STANDBY = 3'b100
  } swm_state_e;
  typedef logic [3:0] swm_period_t;
endpackage : swm_pkg

//--- verif/standby_wake_manager_test.sv
// Self-checking bench for both standby manager ends
`timescale 1ns/1ps
module standby_wake_manager_test;
  logic                 sys_clk;
  logic                 resetn;
  logic                 booted;
  logic [2:0]           req;
  logic                 cfg_en;
  swm_pkg::swm_period_t cfg_sec;
  logic                 powered;
  logic [6:0]           src;
  logic [7:0]           wake_cause;
  logic                 guard_on;
  int                   error_cnt;
  int                   cmp_count;
  swm_link_if swm_link_if_i ();
  swm_device swm_device_i (.sys_clk(sys_clk), .resetn(resetn), .link(swm_link_if_i.dev),
    .key_panel(src[0]), .key_remote(src[1]), .rtc_alarm(src[2]), .rtc_wdog(src[3]),
    .rtc_oscf(src[4]), .wake_pin(src[5]), .gpio_chg(src[6]), .wake_cause(wake_cause),
    .guard_on(guard_on));
  swm_host swm_host_i (.sys_clk(sys_clk), .resetn(resetn), .link(swm_link_if_i.host),
    .booted(booted), .req_standby(req[0]), .req_clear(req[1]), .req_cfg(req[2]),
    .cfg_en(cfg_en), .cfg_sec(cfg_sec), .powered(powered));
  swm_link_chk swm_link_chk_i (.sys_clk(sys_clk), .resetn(resetn),
    .board_power_cut(swm_link_if_i.board_power_cut), .host_ready(swm_link_if_i.host_ready),
    .cmd_standby(swm_link_if_i.cmd_standby), .guard_clear(swm_link_if_i.guard_clear),
    .guard_cfg_wr(swm_link_if_i.guard_cfg_wr), .guard_cfg_en(swm_link_if_i.guard_cfg_en),
    .guard_cfg_sec(swm_link_if_i.guard_cfg_sec));
  ////////////////////////////////////////////////////////////////////////////////
  initial sys_clk = 1'b0;
  always #12.5 sys_clk = ~sys_clk;
  task automatic tick(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : tick
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic expect_state(input logic cut, input logic gon);
    check("board_power_cut", {7'h00, swm_link_if_i.board_power_cut}, {7'h00, cut});
    check("powered", {7'h00, powered}, {7'h00, ~cut});
    check("guard_on", {7'h00, guard_on}, {7'h00, gon});
  endtask : expect_state
  // One-cycle host request pulse
  task automatic send(input logic [2:0] r);
    req = r;
    tick(1);
    req = 3'h0;
    tick(2);
  endtask : send
  task automatic print_verdict;
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : print_verdict
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #(25 * 20000);
    error_cnt++;
    print_verdict();
  end
  initial begin
    resetn = 1'b0;
    booted = 1'b0;
    req = 3'h0;
    cfg_en = 1'b0;
    cfg_sec = 4'h0;
    src = 7'h00;
    error_cnt = 0;
    cmp_count = 0;
    tick(3);
    resetn = 1'b1;
    tick(1);
    expect_state(1'b0, 1'b1);
    check("wake_cause", wake_cause, 8'h00);
    booted = 1'b1;
    tick(3);
    expect_state(1'b0, 1'b0);
    cfg_en = 1'b1;
    cfg_sec = 4'hf;
    send(3'h4);
    expect_state(1'b0, 1'b1);
    cfg_en = 1'b0;
    cfg_sec = 4'h0;
    send(3'h4);
    expect_state(1'b0, 1'b1);
    cfg_sec = 4'h1;
    send(3'h4);
    expect_state(1'b0, 1'b0);
    send(3'h2);
    expect_state(1'b0, 1'b0);
    for (int i = 0; i < 7; i++) begin
      if (i % 2 == 1) begin
        send(3'h1);
      end else begin
        booted = 1'b0;
        tick(3);
      end
      expect_state(1'b1, 1'b0);
      booted = 1'b1;
      send(3'h2);
      expect_state(1'b1, 1'b0);
      src[i] = 1'b1;
      tick(1);
      if (i != 5) src[i] = 1'b0;
      expect_state(1'b0, 1'b1);
      check("wake_cause", wake_cause, 8'h01 << i);
      tick(3);
      expect_state(1'b0, 1'b0);
    end
    send(3'h1);
    tick(4);
    expect_state(1'b1, 1'b0);
    src[5] = 1'b0;
    tick(2);
    expect_state(1'b1, 1'b0);
    src[5] = 1'b1;
    tick(1);
    expect_state(1'b0, 1'b1);
    check("wake_cause", wake_cause, 8'h20);
    print_verdict();
  end
endmodule : standby_wake_manager_test

//--- verif/swm_link_chk.sv
// Checker on the link between device and host ends
`timescale 1ns/1ps
module swm_link_chk (
  input wire logic                 sys_clk,         // Clock
  input wire logic                 resetn,          // Reset, active low
  input wire logic                 board_power_cut, // Cut power
  input wire logic                 host_ready,      // Host ready
  input wire logic                 cmd_standby,     // Standby command
  input wire logic                 guard_clear,     // Guard clear
  input wire logic                 guard_cfg_wr,    // Config strobe
  input wire logic                 guard_cfg_en,    // Keep guard on
  input wire swm_pkg::swm_period_t guard_cfg_sec    // Guard period
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  logic keep_on_q;
  logic keep_on_d;
  // Guard kept running while ready
  assign keep_on_d = (guard_cfg_wr && guard_cfg_sec != 4'h0) ? guard_cfg_en : keep_on_q;
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) keep_on_q <= 1'b0;
    else keep_on_q <= keep_on_d;
  end
  sequence s_ready_drop;
    host_ready ##1 !host_ready;
  endsequence
  sequence s_steady_run;
    !board_power_cut && host_ready && $past(host_ready) && !keep_on_q && !cmd_standby;
  endsequence
  AST_READY_DROP_CUT: assert property (s_ready_drop |=> board_power_cut)
    else $error("power not cut after ready fell");
  AST_CMD_CUT: assert property (cmd_standby |=> board_power_cut)
    else $error("power not cut after standby command");
  AST_BOOT_POWERED: assert property ($rose(resetn) |-> !board_power_cut)
    else $error("board unpowered after reset");
  AST_RUN_STEADY: assert property (s_steady_run |=> !board_power_cut)
    else $error("power cut without cause in run");
  AST_CFG_AFTER_READY: assert property (guard_cfg_wr |-> host_ready)
    else $error("guard configured before ready");
  AST_READY_POWERED: assert property ($rose(host_ready) |-> !$past(board_power_cut))
    else $error("ready rose without power");
  AST_CUT_BLOCKS_READY: assert property (board_power_cut |=> !host_ready)
    else $error("ready high while unpowered");
  AST_CLEAR_IN_STANDBY: assert property (board_power_cut && guard_clear |=> board_power_cut)
    else $error("guard clear ended standby");
endmodule : swm_link_chk
